// ===== hw/amc_top.v
// Function
// - Power bit one powers converter, else off
// - Bits three and two power both buffers
// - Mux enable bit connects selected channel
// - Channel select field in bits seven to four
// - Test bit zero starts temperature conversion
// - Test bit four holds verification mode
// - Pin enable bits gate three analog pins
// - Verify drive bit n forces channel n
// - Start bit reads one from accepted start until conversion done or next power write
// - Result split over low and high registers
// - Driven-low channel converts near zero
// - Driven-high channel converts near full scale
// - Clock enable write gates converter clock
// - Interrupt enables gate flag reporting
// - Reading flag registers clears them
// - Reference ready sets flag bit one
// - Temperature conversion sets done and calibration
// - Normal conversion sets only done flag
// - Temperature result stored in own registers
// - Reference register holds mux and divider
// - Channel zero limits across three registers
// - Limit bits packed into three bytes
// - Limit crossing asserts interrupt when enabled
// - Round-robin enable starts periodic monitoring
// - Flag bit zero done, seven calibration
//
// The APB interface to the registers is this design's own decision.
`include "amc_map.vh"

module amc_top #(
    parameter RR_GAP = `AMC_RR_GAP_CYC
) (
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Converter core control
    output wire converter_power_on,
    output wire reference_buffer_power,
    output wire internal_buffer_power,
    output wire charge_pump_power,
    output wire converter_clock_en,
    output wire [2:0] reference_select,
    output wire mux_enable,
    output wire [3:0] mux_channel,
    output wire [1:0] input_divider,
    output wire [2:0] analog_pin_en,
    output wire mux_verify_mode,
    output wire [7:0] mux_verify_drive_bits,
    output wire conv_start,
    output wire conv_temperature,
    output wire converter_irq,
    // Converter core status
    input wire reference_ready,
    input wire conv_done,
    input wire [9:0] conv_data
);
    localparam S_IDLE = 4'b0001;
    localparam S_START = 4'b0010;
    localparam S_WAIT = 4'b0100;
    localparam S_GAP = 4'b1000;

    reg [31:0] prdata_q;
    reg pready_q;
    reg pslverr_q;
    reg [7:0] glb_ie_q;
    reg [7:0] pwr_q;
    reg [7:0] clkch_q;
    reg [7:0] muxref_q;
    reg [7:0] ie_q;
    reg [7:0] flg0_q;
    reg [7:0] flg1_q;
    reg [7:0] flg2_q;
    reg [9:0] lim_lo_q;
    reg [9:0] lim_hi_q;
    reg [7:0] rr_q;
    reg [2:0] pin_q;
    reg muxv_mode_q;
    reg [7:0] muxv_drv_q;
    reg [9:0] result_q;
    reg [9:0] temp_q;
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg start_q;
    reg temp_run_q;
    reg rr_run_q;
    reg [15:0] gap_q;
    reg rdy_prev_q;
    reg irq_q;

    // Bus decode; a transfer completes on the edge that sees pready
    wire [13:0] idx = paddr[15:2];
    wire xfer = psel & penable & pready_q;
    wire wr = xfer & pwrite;
    wire rd = xfer & ~pwrite;
    reg [7:0] rdata;
    reg hit;

    // Read mux; unmapped addresses answer with an error
    always @*
    begin
        hit = 1'b1;
        case (idx)
            `AMC_IDX_GLB_IE: rdata = glb_ie_q;
            `AMC_IDX_PWR: rdata = pwr_q;
            `AMC_IDX_CLKCH: rdata = clkch_q;
            `AMC_IDX_MUXREF: rdata = muxref_q;
            `AMC_IDX_RES_LO: rdata = result_q[7:0];
            `AMC_IDX_RES_HI: rdata = {6'h00, result_q[9:8]};
            `AMC_IDX_IE: rdata = ie_q;
            `AMC_IDX_FLG0: rdata = flg0_q;
            `AMC_IDX_FLG1: rdata = flg1_q;
            `AMC_IDX_FLG2: rdata = flg2_q;
            `AMC_IDX_FLG3: rdata = 8'h00;
            `AMC_IDX_LIM0: rdata = lim_lo_q[7:0];
            `AMC_IDX_LIM1: rdata = {lim_hi_q[3:0], 2'b00, lim_lo_q[9:8]};
            `AMC_IDX_LIM2: rdata = {2'b00, lim_hi_q[9:4]};
            `AMC_IDX_RR_EN: rdata = rr_q;
            `AMC_IDX_PIN_EN: rdata = {5'h00, pin_q};
            `AMC_IDX_TEST: rdata = {3'h0, muxv_mode_q, 4'h0};
            `AMC_IDX_MUXV: rdata = muxv_drv_q;
            `AMC_IDX_TEMP_A: rdata = temp_q[7:0];
            `AMC_IDX_TEMP_B: rdata = {6'h00, temp_q[9:8]};
            // Third temperature byte is an alternate view of the upper bits
            `AMC_IDX_TEMP_C: rdata = temp_q[9:2];
            default:
            begin
                rdata = 8'h00;
                hit = 1'b0;
            end
        endcase
    end

    // One wait state so read data leaves a flop
    // Writes and read clears act on the later edge that sees pready
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else if (psel & penable & ~pready_q)
        begin
            pready_q <= 1'b1;
            prdata_q <= pwrite ? 32'h00000000 : {24'h000000, rdata};
            pslverr_q <= ~hit;
        end
        else
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Conversion requests from software
    wire clk_on = clkch_q[`AMC_CLK_EN];
    wire sw_start = wr & (idx == `AMC_IDX_PWR) & pwdata[`AMC_PWR_START];
    wire sw_temp = wr & (idx == `AMC_IDX_TEST) & pwdata[`AMC_TST_RUN];
    wire idle = state_q[0];
    // Requests while busy or with clock gated are dropped
    wire req_start = idle & clk_on & sw_start;
    wire req_temp = idle & clk_on & sw_temp;
    wire rr_on = rr_q[`AMC_RR_ON];
    wire req_rr = idle & clk_on & rr_on & ~req_start & ~req_temp;
    wire finish = state_q[2] & conv_done;

    // Sequencer next state
    always @*
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:
                if (req_start | req_temp | req_rr)
                    state_d = S_START;
            S_START:
                state_d = S_WAIT;
            // A done pulse outside the wait state is treated as stray
            S_WAIT:
                if (conv_done)
                    state_d = rr_run_q ? S_GAP : S_IDLE;
            S_GAP:
                if (gap_q == 16'h0000)
                    state_d = S_IDLE;
            default:
                state_d = S_IDLE;
        endcase
    end

    // Sequencer registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= S_IDLE;
            start_q <= 1'b0;
            temp_run_q <= 1'b0;
            rr_run_q <= 1'b0;
            gap_q <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            // Start pulse leaves a flop on the edge that accepts the request
            start_q <= state_q[0] & (state_d == S_START);
            if (state_q[0] & (state_d == S_START))
            begin
                temp_run_q <= req_temp;
                rr_run_q <= req_rr;
            end
            // Gap keeps round robin from hogging the converter
            if (finish)
                gap_q <= RR_GAP[15:0];
            else if (gap_q != 16'h0000)
                gap_q <= gap_q - 16'h0001;
        end
    end

    // Limit comparison for monitored results
    wire over_hi = finish & rr_run_q & (conv_data > lim_hi_q);
    wire under_lo = finish & rr_run_q & (conv_data < lim_lo_q);
    wire rdy_now = pwr_q[`AMC_PWR_ADC] & pwr_q[`AMC_PWR_RBUF]
        & pwr_q[`AMC_PWR_IBUF] & reference_ready;
    wire rdy_rise = rdy_now & ~rdy_prev_q;
    wire clr0 = rd & (idx == `AMC_IDX_FLG0);
    wire clr1 = rd & (idx == `AMC_IDX_FLG1);
    wire clr2 = rd & (idx == `AMC_IDX_FLG2);
    // Clear only the bits the read reported; an event landing between
    // the data latch and the access edge would otherwise vanish unseen
    wire [7:0] keep0 = clr0 ? (flg0_q & ~prdata_q[7:0]) : flg0_q;
    wire [7:0] keep1 = clr1 ? (flg1_q & ~prdata_q[7:0]) : flg1_q;
    wire [7:0] keep2 = clr2 ? (flg2_q & ~prdata_q[7:0]) : flg2_q;

    // Sticky flags; a new event beats the read clear
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flg0_q <= `AMC_RST_BYTE;
            flg1_q <= `AMC_RST_BYTE;
            flg2_q <= `AMC_RST_BYTE;
            rdy_prev_q <= 1'b0;
        end
        else
        begin
            rdy_prev_q <= rdy_now;
            flg0_q <= keep0
                | ({7'h00, finish} << `AMC_FLG_DONE)
                | ({7'h00, rdy_rise} << `AMC_FLG_RDY)
                | ({7'h00, finish & temp_run_q} << `AMC_FLG_CAL);
            flg1_q <= keep1 | {7'h00, over_hi};
            flg2_q <= keep2 | {7'h00, under_lo};
        end
    end

    // Results land in their own registers by conversion kind
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result_q <= `AMC_RST_LIM;
            temp_q <= `AMC_RST_LIM;
        end
        else if (finish)
        begin
            if (temp_run_q)
                temp_q <= conv_data;
            else
                result_q <= conv_data;
        end
    end

    // Software-written control registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            glb_ie_q <= `AMC_RST_BYTE;
            pwr_q <= `AMC_RST_BYTE;
            clkch_q <= `AMC_RST_BYTE;
            muxref_q <= `AMC_RST_BYTE;
            ie_q <= `AMC_RST_BYTE;
            lim_lo_q <= `AMC_RST_LIM;
            lim_hi_q <= `AMC_RST_LIM;
            rr_q <= `AMC_RST_BYTE;
            pin_q <= `AMC_RST_PIN;
            muxv_mode_q <= 1'b0;
            muxv_drv_q <= `AMC_RST_BYTE;
        end
        else
        begin
            if (wr)
            begin
                case (idx)
                    `AMC_IDX_GLB_IE: glb_ie_q <= pwdata[7:0];
                    `AMC_IDX_CLKCH: clkch_q <= pwdata[7:0];
                    `AMC_IDX_MUXREF: muxref_q <= pwdata[7:0];
                    `AMC_IDX_IE: ie_q <= pwdata[7:0];
                    `AMC_IDX_LIM0: lim_lo_q[7:0] <= pwdata[7:0];
                    `AMC_IDX_LIM1:
                    begin
                        lim_lo_q[9:8] <= pwdata[1:0];
                        lim_hi_q[3:0] <= pwdata[7:4];
                    end
                    `AMC_IDX_LIM2: lim_hi_q[9:4] <= pwdata[5:0];
                    `AMC_IDX_RR_EN: rr_q <= pwdata[7:0];
                    `AMC_IDX_PIN_EN: pin_q <= pwdata[2:0];
                    `AMC_IDX_TEST: muxv_mode_q <= pwdata[`AMC_TST_MUXV];
                    `AMC_IDX_MUXV: muxv_drv_q <= pwdata[7:0];
                    // Read-only and unmapped writes fall through untouched
                    default:
                    begin
                    end
                endcase
            end
            // Power bits from writes; start bit set by accepted software start, cleared at its finish
            if (wr & (idx == `AMC_IDX_PWR))
                pwr_q <= {pwdata[7:1], req_start};
            else if (finish & ~temp_run_q & ~rr_run_q)
                pwr_q[`AMC_PWR_START] <= 1'b0;
        end
    end

    // Interrupt: enabled flags gated by the global enable
    // Lags the flags by one edge so the pin leaves a flop
    wire [7:0] en0 = flg0_q & ie_q;
    wire lim_irq = (ie_q[`AMC_IE_HI] & flg1_q[0]) | (ie_q[`AMC_IE_LO] & flg2_q[0]);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_q <= 1'b0;
        else
            irq_q <= (|glb_ie_q) & ((|en0) | lim_irq);
    end

    // Port drive, all from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign converter_power_on = pwr_q[`AMC_PWR_ADC];
    assign reference_buffer_power = pwr_q[`AMC_PWR_RBUF];
    assign internal_buffer_power = pwr_q[`AMC_PWR_IBUF];
    assign charge_pump_power = pwr_q[`AMC_PWR_PUMP];
    assign converter_clock_en = clkch_q[`AMC_CLK_EN];
    assign reference_select = clkch_q[`AMC_REF_MSB:`AMC_REF_LSB];
    assign mux_enable = muxref_q[`AMC_MUX_EN];
    assign mux_channel = clkch_q[`AMC_CH_MSB:`AMC_CH_LSB];
    assign input_divider = muxref_q[`AMC_DIV_MSB:`AMC_DIV_LSB];
    assign analog_pin_en = pin_q;
    assign mux_verify_mode = muxv_mode_q;
    assign mux_verify_drive_bits = muxv_drv_q;
    assign conv_start = start_q;
    assign conv_temperature = temp_run_q;
    assign converter_irq = irq_q;
endmodule

// ===== hw/amc_map.vh
`ifndef AMC_MAP_VH
`define AMC_MAP_VH
// Register indices; byte address is index times four
`define AMC_IDX_GLB_IE 14'h001e
`define AMC_IDX_PWR 14'h0500
`define AMC_IDX_CLKCH 14'h0501
`define AMC_IDX_MUXREF 14'h0502
`define AMC_IDX_RES_LO 14'h0508
`define AMC_IDX_RES_HI 14'h0509
`define AMC_IDX_IE 14'h050c
`define AMC_IDX_FLG0 14'h0510
`define AMC_IDX_FLG1 14'h0511
`define AMC_IDX_FLG2 14'h0512
`define AMC_IDX_FLG3 14'h0513
`define AMC_IDX_LIM0 14'h0514
`define AMC_IDX_LIM1 14'h0515
`define AMC_IDX_LIM2 14'h0516
`define AMC_IDX_RR_EN 14'h0534
`define AMC_IDX_PIN_EN 14'h053e
`define AMC_IDX_TEST 14'h1d28
`define AMC_IDX_MUXV 14'h1d37
`define AMC_IDX_TEMP_A 14'h1d3b
`define AMC_IDX_TEMP_B 14'h1d3c
`define AMC_IDX_TEMP_C 14'h1d3d
// Field positions
`define AMC_PWR_START 0
`define AMC_PWR_ADC 1
`define AMC_PWR_IBUF 2
`define AMC_PWR_RBUF 3
`define AMC_PWR_PUMP 4
`define AMC_CLK_EN 3
`define AMC_CH_MSB 7
`define AMC_CH_LSB 4
`define AMC_MUX_EN 0
`define AMC_DIV_MSB 2
`define AMC_DIV_LSB 1
`define AMC_TST_RUN 0
`define AMC_TST_MUXV 4
`define AMC_FLG_DONE 0
`define AMC_FLG_RDY 1
`define AMC_FLG_CAL 7
`define AMC_IE_HI 2
`define AMC_IE_LO 3
`define AMC_RR_ON 0
`define AMC_REF_MSB 2
`define AMC_REF_LSB 0
// Reset values
`define AMC_RST_BYTE 8'h00
`define AMC_RST_LIM 10'h000
`define AMC_RST_PIN 3'h0
// Round-robin spacing between conversions
`define AMC_RR_GAP_CYC 16
`endif

// ===== testbench/amc_checker.sv
`include "amc_map.vh"
module amc_checker (
    // Bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    // Core control
    input wire logic converter_power_on,
    input wire logic reference_buffer_power,
    input wire logic internal_buffer_power,
    input wire logic converter_clock_en,
    input wire logic [2:0] reference_select,
    input wire logic mux_enable,
    input wire logic [3:0] mux_channel,
    input wire logic [1:0] input_divider,
    input wire logic [2:0] analog_pin_en,
    input wire logic mux_verify_mode,
    input wire logic [7:0] mux_verify_drive_bits,
    input wire logic conv_start,
    input wire logic conv_temperature,
    input wire logic converter_irq
);
    // Completed write and its word index
    wire logic wr = psel && pwrite && pready;
    wire logic [13:0] ix = paddr[15:2];
    // Round robin starts conversions with no write behind them
    logic rr_en_q;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rr_en_q <= 1'b0;
        else if (wr && ix == `AMC_IDX_RR_EN)
            rr_en_q <= pwdata[`AMC_RR_ON];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Controls move only after a write to their own register
    pwr_follow_a: assert property (
        $changed({converter_power_on, reference_buffer_power, internal_buffer_power})
        |-> $past(wr && ix == `AMC_IDX_PWR)) else $error("power bits moved without write");
    mux_follow_a: assert property (
        $changed({mux_enable, input_divider}) |-> $past(wr && ix == `AMC_IDX_MUXREF))
        else $error("mux controls moved without write");
    chan_follow_a: assert property (
        $changed({mux_channel, converter_clock_en, reference_select})
        |-> $past(wr && ix == `AMC_IDX_CLKCH)) else $error("channel moved without write");
    pin_follow_a: assert property (
        $changed(analog_pin_en) |-> $past(wr && ix == `AMC_IDX_PIN_EN))
        else $error("pin enables moved without write");
    verify_mode_a: assert property (
        $changed(mux_verify_mode) |-> $past(wr && ix == `AMC_IDX_TEST))
        else $error("verify mode moved without write");
    drive_follow_a: assert property (
        $changed(mux_verify_drive_bits) |-> $past(wr && ix == `AMC_IDX_MUXV))
        else $error("drive bits moved without write");
    start_pulse_a: assert property (
        conv_start |=> !conv_start) else $error("start longer than one cycle");
    start_clock_a: assert property (
        conv_start |-> $past(converter_clock_en)) else $error("start with clock gated");
    start_write_a: assert property (
        conv_start |-> rr_en_q
        || $past(wr && (ix == `AMC_IDX_PWR || ix == `AMC_IDX_TEST || ix == `AMC_IDX_RR_EN)))
        else $error("start without accepted request");
    cover property (conv_start && conv_temperature);
    cover property (conv_start && mux_verify_mode);
    cover property (converter_irq);
    cover property (conv_start && rr_en_q);
endmodule

bind amc_top amc_checker chk (.*);

// ===== testbench/amc_core_model.sv
module amc_core_model (
    // Block side
    input wire logic pclk,
    input wire logic [2:0] pwr,
    input wire logic vmode,
    input wire logic [7:0] vdrive,
    input wire logic [3:0] ch,
    input wire logic start,
    // Bench knobs
    input wire logic [7:0] lat,
    input wire logic [9:0] val,
    // Core status
    output logic ready = 0,
    output logic done = 0,
    output logic [9:0] data = 0
);
    int cnt = 0;
    int rdy = 0;
    // Reference settles a few cycles after converter and both buffers are powered
    always @(posedge pclk)
    begin
        rdy <= (&pwr) ? rdy + 1 : 0;
        ready <= rdy > 6;
        done <= 0;
        cnt <= start ? int'(lat) : (cnt > 0 ? cnt - 1 : 0);
        // Data toggles outside the done cycle so no stale value lingers
        if (cnt == 1)
        begin
            done <= 1;
            data <= !vmode ? val : (vdrive[ch[2:0]] ? 10'h3d8 : 10'h009);
        end
        else
            data <= ~data;
    end
endmodule

// ===== testbench/adc_monitor_control_tb.sv
`include "amc_map.vh"
module adc_monitor_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slverr;
    logic [15:0] paddr = 0;
    logic [31:0] pwdata = 0, rdat;
    logic [7:0] lat = 10, lo;
    logic [9:0] val = 0;
    logic [3:0] ch;
    int errors = 0, checks_done = 0, cyc = 0, n;
    wire [31:0] prdata;
    wire pready, pslverr, pwr_on, rbuf_on, ibuf_on, pump_on, clk_en, mux_en;
    wire verify, start, temp, irq, ready, done;
    wire [1:0] div;
    wire [2:0] refsel, pins;
    wire [3:0] chan;
    wire [7:0] drive;
    wire [9:0] data;
    amc_top #(.RR_GAP(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .converter_power_on(pwr_on),
        .reference_buffer_power(rbuf_on), .internal_buffer_power(ibuf_on),
        .charge_pump_power(pump_on), .converter_clock_en(clk_en), .reference_select(refsel),
        .mux_enable(mux_en), .mux_channel(chan), .input_divider(div), .analog_pin_en(pins),
        .mux_verify_mode(verify), .mux_verify_drive_bits(drive), .conv_start(start),
        .conv_temperature(temp), .converter_irq(irq), .reference_ready(ready),
        .conv_done(done), .conv_data(data));
    amc_core_model core (.pclk(pclk), .pwr({pwr_on, rbuf_on, ibuf_on}), .vmode(verify),
        .vdrive(drive), .ch(chan), .start(start), .lat(lat), .val(val), .ready(ready),
        .done(done), .data(data));
    initial
    begin
        forever #25 pclk = ~pclk;
    end
    // Hang guard
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            results();
        end
    end
    task automatic results;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic near(input logic [10:0] got, input logic [10:0] exp, input logic [10:0] tol);
        checks_done++;
        if ($isunknown(got) || got > exp + tol || got + tol < exp)
        begin
            errors++;
            $display("[ERR] %0t result %h off %h", $time, got, exp);
        end
    endtask
    // One transfer; holds everything until pready is seen
    task automatic apb(input logic w, input logic [13:0] ix, input logic [7:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdat = prdata;
        slverr = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [13:0] ix, input logic [7:0] e);
        apb(0, ix, 8'h00);
        chk(rdat, {24'h0, e});
    endtask
    task automatic wdone;
        for (n = 0; n < 300 && done !== 1'b1; n++)
            @(posedge pclk);
        if (done !== 1'b1)
        begin
            errors++;
            $display("[ERR] %0t no conversion done", $time);
        end
        repeat (2) @(posedge pclk);
    endtask
    initial
    begin
        logic [13:0] rix [8];
        logic [7:0] dv [2];
        rix = '{`AMC_IDX_PWR, `AMC_IDX_CLKCH, `AMC_IDX_MUXREF, `AMC_IDX_RES_LO,
            `AMC_IDX_RES_HI, `AMC_IDX_FLG0, `AMC_IDX_LIM1, `AMC_IDX_MUXV};
        dv = '{8'hfe, 8'h01};
        void'($urandom(27868));
        repeat (4) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        foreach (rix[i]) rd(rix[i], 8'h00);
        apb(0, 14'h0003, 8'h00);
        chk(slverr, 1);
        // Setup flow
        apb(1, `AMC_IDX_GLB_IE, 8'hff);
        apb(1, `AMC_IDX_CLKCH, 8'h08);
        chk({clk_en, refsel}, 4'h8);
        apb(1, `AMC_IDX_IE, 8'h83);
        apb(1, `AMC_IDX_MUXREF, 8'h00);
        apb(1, `AMC_IDX_PWR, 8'h1e);
        chk({pwr_on, rbuf_on, ibuf_on, pump_on}, 4'hf);
        for (n = 0; n < 100 && irq !== 1'b1; n++)
            @(posedge pclk);
        chk(irq, 1);
        rd(`AMC_IDX_FLG0, 8'h02);
        rd(`AMC_IDX_FLG0, 8'h00);
        // Temperature run
        val <= 10'($urandom);
        apb(1, `AMC_IDX_TEST, 8'h01);
        wdone();
        chk(temp, 1);
        rd(`AMC_IDX_FLG0, 8'h81);
        rd(`AMC_IDX_TEMP_A, val[7:0]);
        rd(`AMC_IDX_TEMP_B, {6'h0, val[9:8]});
        rd(`AMC_IDX_TEMP_C, val[9:2]);
        // Random normal conversions
        repeat (6)
        begin
            ch = 4'($urandom_range(11, 0));
            val <= 10'($urandom);
            lat <= 8'($urandom_range(40, 8));
            apb(1, `AMC_IDX_CLKCH, {ch, 4'h8});
            apb(1, `AMC_IDX_MUXREF, 8'h05);
            chk({mux_en, div, chan}, {3'b110, ch});
            apb(1, `AMC_IDX_PWR, 8'h1f);
            rd(`AMC_IDX_PWR, 8'h1f);
            wdone();
            rd(`AMC_IDX_PWR, 8'h1e);
            rd(`AMC_IDX_FLG0, 8'h01);
            rd(`AMC_IDX_RES_LO, val[7:0]);
            rd(`AMC_IDX_RES_HI, {6'h0, val[9:8]});
        end
        // Verification mode on pin zero
        apb(1, `AMC_IDX_PIN_EN, 8'h05);
        chk(pins, 3'h5);
        apb(1, `AMC_IDX_CLKCH, 8'h08);
        apb(1, `AMC_IDX_TEST, 8'h10);
        chk(verify, 1);
        foreach (dv[i])
        begin
            apb(1, `AMC_IDX_MUXV, dv[i]);
            chk(drive, dv[i]);
            apb(1, `AMC_IDX_PWR, 8'h1f);
            wdone();
            apb(0, `AMC_IDX_RES_LO, 8'h00);
            lo = rdat[7:0];
            apb(0, `AMC_IDX_RES_HI, 8'h00);
            near({1'b0, rdat[1:0], lo}, dv[i][0] ? 11'h3e6 : 11'h0, dv[i][0] ? 11'd35 : 11'd15);
            rd(`AMC_IDX_FLG0, 8'h01);
        end
        apb(1, `AMC_IDX_TEST, 8'h00);
        chk(verify, 0);
        // Limit packing
        apb(1, `AMC_IDX_LIM0, 8'h60);
        apb(1, `AMC_IDX_LIM1, 8'h62);
        apb(1, `AMC_IDX_LIM2, 8'h2e);
        rd(`AMC_IDX_LIM0, 8'h60);
        rd(`AMC_IDX_LIM1, 8'h62);
        rd(`AMC_IDX_LIM2, 8'h2e);
        // Round robin below the low limit, then above the high limit
        foreach (dv[i])
        begin
            val <= dv[i][0] ? 10'h3ff : 10'h100;
            apb(1, `AMC_IDX_RR_EN, 8'h01);
            wdone();
            apb(1, `AMC_IDX_RR_EN, 8'h00);
            repeat (60) @(posedge pclk);
            rd(`AMC_IDX_FLG1, {7'h0, dv[i][0]});
            rd(`AMC_IDX_FLG2, {7'h0, ~dv[i][0]});
            rd(`AMC_IDX_FLG0, 8'h01);
        end
        // Shutdown order, then a start with clock gated
        apb(1, `AMC_IDX_RR_EN, 8'h00);
        apb(1, `AMC_IDX_PWR, 8'h00);
        chk(pwr_on, 0);
        apb(1, `AMC_IDX_CLKCH, 8'h00);
        chk(clk_en, 0);
        apb(1, `AMC_IDX_PWR, 8'h1f);
        repeat (30) @(posedge pclk);
        rd(`AMC_IDX_PWR, 8'h1e);
        rd(`AMC_IDX_FLG0, 8'h02);
        results();
    end
endmodule
